// ==== design/hai_encoder.sv ====
// Hall angle processing, interval logic and quadrature encoder output
`timescale 1ns/1ps
module hai_encoder #(
    parameter int TICK_CYCLES = hai_pkg::HAI_TICK_CYCLES,
    parameter int MISS_W      = 8
) (
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Sensor front end
    input  wire hai_pkg::hai_plate_s plate_in,
    input  wire logic               angle_valid,
    input  wire logic [15:0]        abs_angle,
    output logic [31:0]             plate_setting,
    // User feature logic events
    input  wire logic               freewheel,
    input  wire logic               touch_release,
    output logic                    stream_window,
    output logic                    high_accuracy,
    output logic                    stationary,
    // Quadrature pins
    output hai_pkg::hai_pin_s       encoder_out_a,
    output hai_pkg::hai_pin_s       encoder_out_b
);
    import hai_pkg::*;

    function automatic logic [15:0] hmean(input logic [15:0] a,
                                          input logic [15:0] b);
        logic [16:0] s;
        logic [33:0] p;
        s = {1'b0, a} + {1'b0, b};
        p = {1'b0, a} * {1'b0, b} * 34'h2;
        hmean = (s == 17'h0) ? 16'h0 : 16'(p / {17'h0, s});
    endfunction

    function automatic logic [15:0] sabs(input logic signed [15:0] v);
        sabs = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Register file
    logic [31:0] ctrl_q, target_q, tune_q, filter_q;
    logic [31:0] interval_q, timeout_q, quad_q;
    logic [15:0] offset_q, offset_d;
    logic [15:0] ref_q [4];
    logic [7:0]  set_q [4];

    wire acc     = psel & penable & ce;
    wire wr      = acc & pwrite;
    wire a_ref   = paddr >= HAI_REF0_OFS && paddr < HAI_REF0_OFS + 8'h10;
    wire a_rw    = paddr <= HAI_OFFSET_OFS;
    wire mapped  = (a_rw || paddr == HAI_STATUS_OFS ||
                    paddr == HAI_ANGLE_OFS || a_ref) && paddr[1:0] == 2'h0;
    wire wr_ok   = wr & mapped & a_rw;
    wire zero_now = wr_ok && paddr == HAI_CTRL_OFS && pwdata[HAI_ZERO_BIT];

    assign pready  = ce;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= HAI_CTRL_RST;
            target_q   <= HAI_TARGET_RST;
            tune_q     <= HAI_TUNE_RST;
            filter_q   <= HAI_FILTER_RST;
            interval_q <= HAI_INTERVAL_RST;
            timeout_q  <= HAI_TIMEOUT_RST;
            quad_q     <= HAI_QUAD_RST;
        end else if (wr_ok) begin
            case (paddr)
                HAI_CTRL_OFS:     ctrl_q <= {20'h0, 1'b0, pwdata[10:0]};
                HAI_TARGET_OFS:   target_q <= pwdata;
                HAI_TUNE_OFS:     tune_q <= {24'h0, pwdata[7:0]};
                HAI_FILTER_OFS:   filter_q <= {8'h0, pwdata[23:0]};
                HAI_INTERVAL_OFS: interval_q <= {8'h0, pwdata[23:0]};
                HAI_TIMEOUT_OFS:  timeout_q <= pwdata;
                HAI_QUAD_OFS:     quad_q <= {12'h0, pwdata[19:0]};
                default:          ;
            endcase
        end
    end

    // Field decode
    wire [15:0] tgt_min  = target_q[15:0];
    wire [15:0] tgt_max  = target_q[31:16];
    wire [7:0]  band_div = (tune_q[7:0] == 8'h0) ? 8'h1 : tune_q[7:0];
    wire [3:0]  slow_b   = filter_q[3:0];
    wire [3:0]  fast_b   = filter_q[7:4];
    wire [15:0] sw_thr   = filter_q[23:8];
    wire [7:0]  n_int    = (interval_q[7:0] == 8'h0) ? 8'h1 : interval_q[7:0];
    wire [15:0] hyst     = interval_q[23:8];
    wire [15:0] flank    = (quad_q[15:0] == 16'h0) ? 16'h1 : quad_q[15:0];
    wire [3:0]  az_beta  = quad_q[19:16];
    wire hai_az_e  az_mode  = hai_az_e'(ctrl_q[HAI_AZ_LSB +: 2]);
    wire hai_ofs_e ofs_mode = hai_ofs_e'(ctrl_q[HAI_OFSM_LSB +: 2]);

    // Plate references and tuning
    logic       tuning_q;
    logic [3:0] ok_q;
    wire [15:0] ref_new  = hmean(plate_in.normal, plate_in.inverted);
    wire [16:0] tgt_mid  = ({1'b0, tgt_max} + {1'b0, tgt_min}) >> 1;
    wire [15:0] band     = (tgt_max - tgt_min) / {8'h0, band_div};
    logic [3:0] off_band;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            off_band[i] = sabs(16'(tgt_mid[15:0] - ref_q[i])) > band;
        end
    end
    wire retune = stationary & ctrl_q[HAI_RT_TUNE_BIT] & (|off_band)
                  & ~tuning_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tuning_q <= 1'b1;
            ok_q     <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                ref_q[i] <= 16'h0;
                set_q[i] <= HAI_SETTING_RST;
            end
        end else if (ce) begin
            if (retune) begin
                tuning_q <= 1'b1;
                ok_q     <= 4'h0;
            end else if (tuning_q && ok_q == 4'hF) begin
                tuning_q <= 1'b0;
            end
            if (plate_in.valid) begin
                ref_q[plate_in.plate] <= ref_new;
                if (tuning_q && !retune) begin
                    // Settings step one code per sample, saturating
                    if (ref_new < tgt_min && set_q[plate_in.plate] != 8'hFF) begin
                        set_q[plate_in.plate] <= set_q[plate_in.plate] + 8'h1;
                        ok_q[plate_in.plate]  <= 1'b0;
                    end else if (ref_new > tgt_max &&
                                 set_q[plate_in.plate] != 8'h00) begin
                        set_q[plate_in.plate] <= set_q[plate_in.plate] - 8'h1;
                        ok_q[plate_in.plate]  <= 1'b0;
                    end else begin
                        ok_q[plate_in.plate]  <= 1'b1;
                    end
                end
            end
        end
    end
    assign plate_setting = {set_q[3], set_q[2], set_q[1], set_q[0]};

    // Angle filters
    logic [15:0] slow_q, fast_q, proc_q;
    logic        upd_q, fast_sel_q;
    wire [15:0]  corrected = abs_angle + offset_q;
    wire signed [15:0] sd = signed'(corrected - slow_q);
    wire signed [15:0] fd = signed'(corrected - fast_q);
    wire [15:0]  split   = sabs(signed'(fast_q - slow_q));
    wire         fast_on = split > sw_thr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_q     <= 16'h0;
            fast_q     <= 16'h0;
            proc_q     <= 16'h0;
            upd_q      <= 1'b0;
            fast_sel_q <= 1'b0;
        end else if (ce) begin
            upd_q <= angle_valid;
            if (angle_valid) begin
                slow_q <= slow_q + 16'(sd >>> slow_b);
                fast_q <= fast_q + 16'(fd >>> fast_b);
            end
            if (upd_q) begin
                fast_sel_q <= fast_on;
                proc_q     <= fast_on ? fast_q : slow_q;
            end
        end
    end

    // Interval decision with hysteresis
    logic [7:0]  idx_q;
    wire [16:0]  isize  = 17'h10000 / {9'h0, n_int};
    wire [15:0]  half   = isize[16:1];
    wire [16:0]  idx_raw = {1'b0, proc_q} / isize;
    wire [7:0]   idx_new = (idx_raw >= {9'h0, n_int}) ? n_int - 8'h1
                                                      : idx_raw[7:0];
    wire [24:0]  ctr_w  = {8'h0, isize} * {17'h0, idx_q};
    wire [15:0]  center = ctr_w[15:0] + half;
    wire signed [15:0] cerr = signed'(center - proc_q);
    wire [16:0]  bound  = {1'b0, half} + {1'b0, hyst};
    wire         int_chg = upd_q && ({1'b0, sabs(cerr)} > bound)
                           && idx_new != idx_q;
    logic signed [9:0] step;
    always_comb begin
        step = 10'(signed'({2'b00, idx_new}) - signed'({2'b00, idx_q}));
        if (step > signed'({2'b00, n_int[7:1]})) begin
            step = step - signed'({2'b00, n_int});
        end else if (step < -signed'({2'b00, n_int[7:1]})) begin
            step = step + signed'({2'b00, n_int});
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 8'h0;
        end else if (ce && int_chg) begin
            idx_q <= idx_new;
        end
    end
    assign stream_window = int_chg & ctrl_q[HAI_STREAM_BIT] & ce;

    // Millisecond tick, high accuracy and stationary timers
    logic [31:0] tick_cnt_q;
    logic [15:0] ha_cnt_q, st_cnt_q;
    logic        ha_prev_q, st_prev_q;
    wire tick    = tick_cnt_q == 32'(TICK_CYCLES - 1);
    wire ha_trig = int_chg | (freewheel & ctrl_q[HAI_FORCE_HA_BIT])
                   | (upd_q & fast_on);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0;
            ha_cnt_q   <= 16'h0;
            st_cnt_q   <= 16'h0;
            ha_prev_q  <= 1'b0;
            st_prev_q  <= 1'b0;
        end else if (ce) begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            ha_prev_q  <= high_accuracy;
            st_prev_q  <= stationary;
            if (ha_trig) begin
                ha_cnt_q <= timeout_q[15:0];
            end else if (tick && ha_cnt_q != 16'h0) begin
                ha_cnt_q <= ha_cnt_q - 16'h1;
            end
            if (ha_trig) begin
                st_cnt_q <= 16'h0;
            end else if (tick && !stationary) begin
                st_cnt_q <= st_cnt_q + 16'h1;
            end
        end
    end
    assign high_accuracy = ha_cnt_q != 16'h0;
    assign stationary    = st_cnt_q >= timeout_q[31:16];
    wire ha_exit  = ha_prev_q & ~high_accuracy;
    wire st_enter = stationary & ~st_prev_q;

    // Offset compensation and centering
    logic started_q;
    wire az_event = (az_mode == HAI_AZ_STAT || az_mode == HAI_AZ_REL) &&
                    ((ha_exit && ctrl_q[HAI_HA_CTR_BIT]) ||
                     (st_enter && ctrl_q[HAI_ST_CTR_BIT]));
    wire rel_event = az_mode == HAI_AZ_REL && touch_release;
    wire cont_pull = az_mode == HAI_AZ_CONT && upd_q;
    wire [15:0] az_step = (az_beta == 4'h0) ? cerr : 16'(cerr >>> az_beta);
    wire [15:0] zero_err = half - proc_q;
    wire start_cap = ofs_mode == HAI_OFS_STARTUP && !started_q && upd_q;
    wire auto_ok   = ofs_mode != HAI_OFS_MANUAL;
    always_comb begin
        offset_d = offset_q;
        if (wr_ok && paddr == HAI_OFFSET_OFS) begin
            offset_d = pwdata[15:0];
        end else if (zero_now) begin
            offset_d = offset_q + zero_err;
        end else if (start_cap) begin
            offset_d = offset_q + zero_err;
        end else if (auto_ok && (az_event || rel_event)) begin
            offset_d = offset_q + (az_beta == 4'h0 ? cerr : az_step);
        end else if (auto_ok && cont_pull) begin
            offset_d = offset_q + az_step;
        end
        // Manual offset mode leaves offset to software alone
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_q  <= 16'h0;
            started_q <= 1'b0;
        end else if (ce) begin
            offset_q <= offset_d;
            if (upd_q) begin
                started_q <= 1'b1;
            end
        end
    end

    // Pending steps and quadrature sequencer
    localparam logic signed [MISS_W-1:0] MISS_MAX = {1'b0, {(MISS_W-1){1'b1}}};
    localparam logic signed [MISS_W-1:0] MISS_MIN = {1'b1, {(MISS_W-1){1'b0}}};
    logic signed [MISS_W-1:0] miss_q;
    logic signed [MISS_W+1:0] miss_sum;
    hai_qstate_e qs_q;
    logic [15:0] qt_q;
    logic        qa_q, qb_q, qdir_q;
    wire qt_done    = qt_q == 16'h0;
    // Gap end may launch the next step at once
    wire q_free     = qs_q == HAI_QS_IDLE || (qs_q == HAI_QS_GAP && qt_done);
    wire start_step = q_free && miss_q != '0;
    always_comb begin
        miss_sum = (MISS_W+2)'(miss_q) + (int_chg ? (MISS_W+2)'(step) : '0);
        if (start_step) begin
            miss_sum = miss_sum - (miss_q[MISS_W-1] ? -(MISS_W+2)'(1)
                                                    : (MISS_W+2)'(1));
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miss_q <= '0;
        end else if (ce) begin
            if (st_enter && ctrl_q[HAI_DISCARD_BIT]) begin
                miss_q <= '0;
            end else if (miss_sum > (MISS_W+2)'(MISS_MAX)) begin
                miss_q <= MISS_MAX;
            end else if (miss_sum < (MISS_W+2)'(MISS_MIN)) begin
                miss_q <= MISS_MIN;
            end else begin
                miss_q <= MISS_W'(miss_sum);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qs_q   <= HAI_QS_IDLE;
            qt_q   <= 16'h0;
            qa_q   <= 1'b0;
            qb_q   <= 1'b0;
            qdir_q <= 1'b0;
        end else if (ce) begin
            if (!qt_done) begin
                qt_q <= qt_q - 16'h1;
            end
            case (qs_q)
                HAI_QS_IDLE, HAI_QS_GAP: begin
                    if (start_step) begin
                        qdir_q <= ~miss_q[MISS_W-1];
                        if (!miss_q[MISS_W-1]) begin
                            qa_q <= ~qa_q;
                        end else begin
                            qb_q <= ~qb_q;
                        end
                        qt_q <= flank - 16'h1;
                        qs_q <= HAI_QS_SECOND;
                    end else if (qt_done) begin
                        qs_q <= HAI_QS_IDLE;
                    end
                end
                HAI_QS_SECOND: begin
                    if (qt_done) begin
                        if (qdir_q) begin
                            qb_q <= ~qb_q;
                        end else begin
                            qa_q <= ~qa_q;
                        end
                        qt_q <= flank - 16'h1;
                        qs_q <= HAI_QS_GAP;
                    end
                end
                default: qs_q <= HAI_QS_IDLE;
            endcase
        end
    end

    // Open drain pulls low only; push-pull always drives
    wire od = ctrl_q[HAI_QUAD_OD_BIT];
    assign encoder_out_a = '{out: od ? 1'b0 : qa_q, oe: od ? ~qa_q : 1'b1};
    assign encoder_out_b = '{out: od ? 1'b0 : qb_q, oe: od ? ~qb_q : 1'b1};

    // Read data
    wire [31:0] status_w = {8'h0, 8'(miss_q), idx_q, 4'h0, fast_sel_q,
                            tuning_q, stationary, high_accuracy};
    always_comb begin
        prdata = 32'h0;
        if (psel && !pwrite && mapped) begin
            case (paddr)
                HAI_CTRL_OFS:     prdata = ctrl_q;
                HAI_TARGET_OFS:   prdata = target_q;
                HAI_TUNE_OFS:     prdata = tune_q;
                HAI_FILTER_OFS:   prdata = filter_q;
                HAI_INTERVAL_OFS: prdata = interval_q;
                HAI_TIMEOUT_OFS:  prdata = timeout_q;
                HAI_QUAD_OFS:     prdata = quad_q;
                HAI_OFFSET_OFS:   prdata = {16'h0, offset_q};
                HAI_STATUS_OFS:   prdata = status_w;
                HAI_ANGLE_OFS:    prdata = {16'h0, proc_q};
                default:          prdata = {16'h0, ref_q[paddr[3:2] - 2'h2]};
            endcase
        end
    end

endmodule

// ==== design/hai_pkg.sv ====
// Package: register map, reset values, timing constants and carriers
package hai_pkg;

    // Register byte offsets
    localparam logic [7:0] HAI_CTRL_OFS     = 8'h00;
    localparam logic [7:0] HAI_TARGET_OFS   = 8'h04;
    localparam logic [7:0] HAI_TUNE_OFS     = 8'h08;
    localparam logic [7:0] HAI_FILTER_OFS   = 8'h0C;
    localparam logic [7:0] HAI_INTERVAL_OFS = 8'h10;
    localparam logic [7:0] HAI_TIMEOUT_OFS  = 8'h14;
    localparam logic [7:0] HAI_QUAD_OFS     = 8'h18;
    localparam logic [7:0] HAI_OFFSET_OFS   = 8'h1C;
    localparam logic [7:0] HAI_STATUS_OFS   = 8'h20;
    localparam logic [7:0] HAI_ANGLE_OFS    = 8'h24;
    localparam logic [7:0] HAI_REF0_OFS     = 8'h28;

    // Control field positions
    localparam int HAI_RT_TUNE_BIT  = 0;
    localparam int HAI_FORCE_HA_BIT = 1;
    localparam int HAI_STREAM_BIT   = 2;
    localparam int HAI_DISCARD_BIT  = 3;
    localparam int HAI_QUAD_OD_BIT  = 4;
    localparam int HAI_HA_CTR_BIT   = 5;
    localparam int HAI_ST_CTR_BIT   = 6;
    localparam int HAI_AZ_LSB       = 7;
    localparam int HAI_OFSM_LSB     = 9;
    localparam int HAI_ZERO_BIT     = 11;

    // Reset values
    localparam logic [31:0] HAI_CTRL_RST     = 32'h0000_0060;
    localparam logic [31:0] HAI_TARGET_RST   = 32'h0C00_0400;
    localparam logic [31:0] HAI_TUNE_RST     = 32'h0000_0008;
    localparam logic [31:0] HAI_FILTER_RST   = 32'h0002_0014;
    localparam logic [31:0] HAI_INTERVAL_RST = 32'h0000_4018;
    localparam logic [31:0] HAI_TIMEOUT_RST  = 32'h01F4_0064;
    localparam logic [31:0] HAI_QUAD_RST     = 32'h0000_0190;
    localparam logic [7:0]  HAI_SETTING_RST  = 8'h80;

    // Timing: one timer tick per millisecond
    localparam int HAI_CLK_NS  = 25;
    localparam int HAI_TICK_NS = 1000000;
    localparam int HAI_TICK_CYCLES = HAI_TICK_NS / HAI_CLK_NS;

    typedef enum logic [1:0] {
        HAI_AZ_OFF = 2'h0, HAI_AZ_STAT = 2'h1,
        HAI_AZ_CONT = 2'h2, HAI_AZ_REL = 2'h3
    } hai_az_e;

    typedef enum logic [1:0] {
        HAI_OFS_MANUAL = 2'h0, HAI_OFS_STARTUP = 2'h1, HAI_OFS_AUTO = 2'h2
    } hai_ofs_e;

    typedef enum logic [2:0] {
        HAI_QS_IDLE = 3'b001, HAI_QS_SECOND = 3'b010, HAI_QS_GAP = 3'b100
    } hai_qstate_e;

    // One plate sample pair from the front end
    typedef struct packed {
        logic        valid;
        logic [1:0]  plate;
        logic [15:0] normal;
        logic [15:0] inverted;
    } hai_plate_s;

    // One quadrature pin as output and enable
    typedef struct packed {
        logic out;
        logic oe;
    } hai_pin_s;

endpackage

// ==== verif/hai_encoder_sva.sv ====
// Port-level checks for the Hall interval encoder
`timescale 1ns/1ps
module hai_encoder_sva (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // Bus and events
    input wire logic              ce,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              stream_window,
    input wire logic              high_accuracy,
    // Quadrature pins
    input wire hai_pkg::hai_pin_s encoder_out_a,
    input wire hai_pkg::hai_pin_s encoder_out_b
);
    import hai_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Released lines read high through pull-ups
    wire lvl_a = encoder_out_a.oe ? encoder_out_a.out : 1'b1;
    wire lvl_b = encoder_out_b.oe ? encoder_out_b.out : 1'b1;
    sequence pins_still;
        ($stable(lvl_a) && $stable(lvl_b)) [*3];
    endsequence
    chk_ready_ce: assert property (pready == ce) else $error("bad ready");
    chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    chk_err_nodata: assert property (pslverr |-> prdata == 32'h0)
        else $error("data with error");
    chk_od_release: assert property (
        (encoder_out_a.oe || !encoder_out_a.out) &&
        (encoder_out_b.oe || !encoder_out_b.out)) else $error("pin drives high");
    chk_one_edge: assert property (
        !($changed(lvl_a) && $changed(lvl_b))) else $error("both pins moved");
    chk_flank_gap: assert property (
        ($changed(lvl_a) || $changed(lvl_b)) |=> pins_still)
        else $error("flank too soon");
    chk_stream_once: assert property (
        stream_window |=> !stream_window) else $error("window too long");
    chk_ha_entry: assert property (
        stream_window |-> ##[0:2] high_accuracy) else $error("no accuracy");
endmodule

// ==== verif/hai_qdec.sv ====
// Quadrature decoder model watching the two output pins
`timescale 1ns/1ps
module hai_qdec (
    // Clock, reset and pins
    input wire logic              pclk,
    input wire logic              presetn,
    input wire hai_pkg::hai_pin_s pin_a,
    input wire hai_pkg::hai_pin_s pin_b,
    // Net flank count, two per interval
    output int                    edges
);
    import hai_pkg::*;
    logic a_q, b_q;
    // Pull-ups lift released lines
    wire a = pin_a.oe ? pin_a.out : 1'b1;
    wire b = pin_b.oe ? pin_b.out : 1'b1;
    // Leading pin gives the direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) edges <= 0;
        else if (a !== a_q) edges <= edges + ((a != b) ? 1 : -1);
        else if (b !== b_q) edges <= edges + ((a == b) ? 1 : -1);
        a_q <= a;
        b_q <= b;
    end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the Hall interval encoder
`timescale 1ns/1ps
module tb;
    import hai_pkg::*;
    logic        pclk, presetn, ce, psel, penable, pwrite, perr, pready;
    logic        angle_valid, freewheel, touch_release, pslverr;
    logic        stream_window, high_accuracy, stationary;
    logic [7:0]  paddr;
    logic [15:0] abs_angle;
    logic [31:0] pwdata, prdata, v, setting;
    hai_plate_s  plate_in;
    hai_pin_s    pin_a, pin_b;
    int          failures, num_checks, edges, pulses;
    hai_encoder #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .plate_in(plate_in), .angle_valid(angle_valid),
        .abs_angle(abs_angle), .plate_setting(setting), .freewheel(freewheel),
        .touch_release(touch_release), .stream_window(stream_window),
        .high_accuracy(high_accuracy), .stationary(stationary),
        .encoder_out_a(pin_a), .encoder_out_b(pin_b));
    hai_qdec dec_u (.pclk(pclk), .presetn(presetn), .pin_a(pin_a),
        .pin_b(pin_b), .edges(edges));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (stream_window === 1'b1) pulses <= pulses + 1;
    task automatic chk(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t %s: %h vs %h", $time, m, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mk, e,
                      input string m);
        apb(1'b0, a, 32'h0);
        chk(v & mk, e, m);
    endtask
    // Long runs of one angle let both filters settle
    task automatic feed(input logic [15:0] ang);
        repeat (40) begin
            @(posedge pclk);
            {angle_valid, abs_angle} <= {1'b1, ang};
            @(posedge pclk);
            angle_valid <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        wrap_up();
    end
    initial begin
        int e0, p0;
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, angle_valid, freewheel, touch_release} = '0;
        {paddr, abs_angle, pwdata} = '0;
        plate_in = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(HAI_CTRL_OFS, '1, HAI_CTRL_RST, "ctrl");
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(perr), 32'h1, "unmapped");
        // Weak plate 0 sample forces one tuning step
        @(posedge pclk);
        plate_in <= '{1'b1, 2'h0, 16'h0200, 16'h0200};
        for (int p = 0; p < 4; p++) begin
            @(posedge pclk);
            plate_in <= '{1'b1, 2'(p), 16'h0600, 16'h0C00};
            @(posedge pclk);
            plate_in <= '0;
        end
        repeat (20) @(posedge pclk);
        rd(HAI_REF0_OFS, 32'hFFFF, 32'h0800, "ref");
        rd(HAI_STATUS_OFS, 32'h4, 32'h0, "tuned");
        chk(setting, 32'h8080_8081, "tune step");
        $display("front end done");
        apb(1'b1, HAI_INTERVAL_OFS, 32'h0000_4010);
        apb(1'b1, HAI_FILTER_OFS, 32'h0002_0000);
        apb(1'b1, HAI_QUAD_OFS, 32'h0000_0004);
        apb(1'b1, HAI_TIMEOUT_OFS, 32'h0014_0003);
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_0064);
        feed(16'h0800);
        rd(HAI_ANGLE_OFS, 32'hFFFF, 32'h0800, "angle");
        p0 = pulses;
        feed(16'h1030);
        rd(HAI_STATUS_OFS, 32'hFF00, 32'h0, "hyst");
        feed(16'h1800);
        chk(32'(pulses - p0), 32'h1, "stream");
        rd(HAI_STATUS_OFS, 32'hFF00, 32'h0100, "index");
        feed(16'h4800);
        repeat (60) @(posedge pclk);
        chk(32'(edges), 32'h8, "forward");
        chk(32'(high_accuracy), 32'h0, "ha end");
        feed(16'h0800);
        repeat (60) @(posedge pclk);
        chk(32'(edges), 32'h0, "back");
        repeat (250) @(posedge pclk);
        chk(32'(stationary), 32'h1, "still");
        feed(16'h0900);
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_0864);
        feed(16'h0900);
        rd(HAI_ANGLE_OFS, 32'hFFFF, 32'h0800, "zero");
        feed(16'h0980);
        repeat (60) @(posedge pclk);
        rd(HAI_ANGLE_OFS, 32'hFFFF, 32'h0880, "az off");
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_0066);
        freewheel <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'(high_accuracy), 32'h1, "freewheel");
        freewheel <= 1'b0;
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_0074);
        e0 = edges;
        feed(16'h1900);
        repeat (40) @(posedge pclk);
        chk(32'(edges - e0), 32'h2, "od step");
        apb(1'b1, HAI_QUAD_OFS, 32'h0000_0190);
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_007C);
        e0 = edges;
        feed(16'h8900);
        repeat (2000) @(posedge pclk);
        chk(32'(edges - e0), 32'h2, "discard");
        $display("interval and pin tests done");
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_04A6);
        feed(16'h8A00);
        freewheel <= 1'b1;
        @(posedge pclk);
        freewheel <= 1'b0;
        repeat (60) @(posedge pclk);
        feed(16'h8A00);
        rd(HAI_ANGLE_OFS, 32'hFFFF, 32'h8800, "az stat");
        apb(1'b1, HAI_CTRL_OFS, 32'h0000_0584);
        feed(16'h8B00);
        touch_release <= 1'b1;
        @(posedge pclk);
        touch_release <= 1'b0;
        feed(16'h8B00);
        rd(HAI_ANGLE_OFS, 32'hFFFF, 32'h8800, "az release");
        $display("auto-zero tests done");
        wrap_up();
    end
endmodule
bind hai_encoder hai_encoder_sva chk_u (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stream_window(stream_window),
    .high_accuracy(high_accuracy), .encoder_out_a(encoder_out_a),
    .encoder_out_b(encoder_out_b));
